// >>> dif_top.sv
// Eight-channel filtered digital input with edge and fault interrupts,
// registers reached over AXI4-Lite.
// Assumes inputs and fault detector flags synchronous to aclk.
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
module dif_top
    import dif_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
)(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [DATA_W-1:0]   s_axi_wdata,
    input  wire logic [DATA_W/8-1:0] s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic [NCH-1:0]      in_raw,
    input  wire logic [NCH-1:0]      short_det,
    input  wire logic [NCH-1:0]      open_det,
    output logic                     irq,
    output logic                     group_fault_indicator,
    output logic [NCH-1:0]           chan_fault
);
    dif_filt_if fi ();

    dif_tick_div #(
        .DIV     (TICK_DIV)
    ) u_div (
        .aclk    (aclk),
        .aresetn (aresetn),
        .fi      (fi)
    );

    dif_debounce u_deb (
        .aclk    (aclk),
        .aresetn (aresetn),
        .fi      (fi)
    );

    // Register state
    logic [1:0]        dly_sel;
    logic              diag_ie;
    logic              hw_ie;
    logic [NCH-1:0]    sc_en;
    logic [NCH-1:0]    wb_en;
    logic [NCH-1:0]    rise_en;
    logic [NCH-1:0]    fall_en;
    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] mask;
    logic [1:0]        next_dly_sel;
    logic              next_diag_ie;
    logic              next_hw_ie;
    logic [NCH-1:0]    next_sc_en;
    logic [NCH-1:0]    next_wb_en;
    logic [NCH-1:0]    next_rise_en;
    logic [NCH-1:0]    next_fall_en;
    logic [DATA_W-1:0] next_status;
    logic [DATA_W-1:0] next_mask;
    logic              next_irq;
    logic              next_group_fault;
    logic [NCH-1:0]    next_chan_fault;

    // Bus state
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] aw_addr;
    logic [DATA_W-1:0] w_data;
    logic [DATA_W-1:0] w_bits;
    logic              next_aw_got;
    logic              next_w_got;
    logic [ADDR_W-1:0] next_aw_addr;
    logic [DATA_W-1:0] next_w_data;
    logic [DATA_W-1:0] next_w_bits;
    logic              next_awready;
    logic              next_wready;
    logic              next_bvalid;
    logic [1:0]        next_bresp;
    logic              next_arready;
    logic              next_rvalid;
    logic [DATA_W-1:0] next_rdata;
    logic [1:0]        next_rresp;

    logic              wr_do;
    logic [DATA_W-1:0] wr_val;
    logic [NCH-1:0]    sc_rep;
    logic [NCH-1:0]    wb_rep;
    logic [DATA_W-1:0] events;
    logic [DATA_W-1:0] gate;

    // Debounce limit follows the module-wide delay selection
    always_comb
    begin
        case (dly_sel)
            2'h0:    fi.limit = DLY0_TICKS;
            2'h1:    fi.limit = DLY1_TICKS;
            2'h2:    fi.limit = DLY2_TICKS;
            default: fi.limit = DLY3_TICKS;
        endcase
    end
    assign fi.raw = in_raw;

    // A write is committed once both address and data have been taken
    assign wr_do  = aw_got && w_got && !s_axi_bvalid;
    assign wr_val = w_data & w_bits;

    always_comb
    begin
        next_aw_got  = aw_got;
        next_w_got   = w_got;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_bits  = w_bits;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_rvalid  = s_axi_rvalid;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_got  = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_got  = 1'b1;
            next_w_data = s_axi_wdata;
            for (int b = 0; b < DATA_W/8; b++)
            begin
                next_w_bits[b*8 +: 8] = {8{s_axi_wstrb[b]}};
            end
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            next_bvalid = 1'b0;
        end
        if (wr_do)
        begin
            next_aw_got = 1'b0;
            next_w_got  = 1'b0;
            next_bvalid = 1'b1;
            case (aw_addr)
                OFS_CTRL, OFS_SC_EN, OFS_WB_EN, OFS_RISE_EN, OFS_FALL_EN,
                OFS_LEVEL, OFS_STATUS, OFS_MASK: next_bresp = RESP_OKAY;
                default:                         next_bresp = RESP_SLVERR;
            endcase
        end
        if (s_axi_rvalid && s_axi_rready)
        begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            next_rdata  = '0;
            case (s_axi_araddr)
                OFS_CTRL:
                begin
                    next_rdata[CTRL_DLY_LSB +: 2] = dly_sel;
                    next_rdata[CTRL_DIAG_IE]      = diag_ie;
                    next_rdata[CTRL_HW_IE]        = hw_ie;
                end
                OFS_SC_EN:   next_rdata[NCH-1:0] = sc_en;
                OFS_WB_EN:   next_rdata[NCH-1:0] = wb_en;
                OFS_RISE_EN: next_rdata[NCH-1:0] = rise_en;
                OFS_FALL_EN: next_rdata[NCH-1:0] = fall_en;
                OFS_LEVEL:   next_rdata[NCH-1:0] = fi.level;
                OFS_STATUS:  next_rdata          = status;
                OFS_MASK:    next_rdata          = mask;
                default:     next_rresp          = RESP_SLVERR;
            endcase
        end
        // Ready is withheld while a word waits, so nothing is ever dropped
        next_awready = !next_aw_got && !next_bvalid;
        next_wready  = !next_w_got && !next_bvalid;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            aw_addr       <= '0;
            w_data        <= '0;
            w_bits        <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end
        else
        begin
            aw_got        <= next_aw_got;
            w_got         <= next_w_got;
            aw_addr       <= next_aw_addr;
            w_data        <= next_w_data;
            w_bits        <= next_w_bits;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
    end

    // Faults count only on channels whose diagnosis is enabled
    assign sc_rep = short_det & sc_en;
    assign wb_rep = open_det & wb_en;

    always_comb
    begin
        events = '0;
        events[ST_RISE +: NCH] = fi.rise & rise_en & {NCH{hw_ie}};
        events[ST_FALL +: NCH] = fi.fall & fall_en & {NCH{hw_ie}};
        events[ST_SC +: NCH]   = sc_rep;
        events[ST_WB +: NCH]   = wb_rep;
        gate = '0;
        gate[ST_RISE +: 2*NCH] = {2*NCH{hw_ie}};
        gate[ST_SC +: 2*NCH]   = {2*NCH{diag_ie}};
    end

    always_comb
    begin
        next_dly_sel = dly_sel;
        next_diag_ie = diag_ie;
        next_hw_ie   = hw_ie;
        next_sc_en   = sc_en;
        next_wb_en   = wb_en;
        next_rise_en = rise_en;
        next_fall_en = fall_en;
        next_mask    = mask;
        next_status  = status;
        if (wr_do)
        begin
            case (aw_addr)
                OFS_CTRL:
                begin
                    if (w_bits[CTRL_DLY_LSB])
                    begin
                        next_dly_sel = w_data[CTRL_DLY_LSB +: 2];
                        next_diag_ie = w_data[CTRL_DIAG_IE];
                        next_hw_ie   = w_data[CTRL_HW_IE];
                    end
                end
                OFS_SC_EN: next_sc_en = (sc_en & ~w_bits[NCH-1:0]) | wr_val[NCH-1:0];
                OFS_WB_EN: next_wb_en = (wb_en & ~w_bits[NCH-1:0]) | wr_val[NCH-1:0];
                // Edge enables are refused while the module hardware enable is off
                OFS_RISE_EN:
                begin
                    if (hw_ie)
                    begin
                        next_rise_en = (rise_en & ~w_bits[NCH-1:0]) | wr_val[NCH-1:0];
                    end
                end
                OFS_FALL_EN:
                begin
                    if (hw_ie)
                    begin
                        next_fall_en = (fall_en & ~w_bits[NCH-1:0]) | wr_val[NCH-1:0];
                    end
                end
                OFS_STATUS: next_status = status & ~wr_val;
                OFS_MASK:   next_mask   = (mask & ~w_bits) | wr_val;
                default:    next_mask   = mask;
            endcase
        end
        // Applied after the clear so a same-cycle event is never lost
        next_status = next_status | events;
        next_irq = |(next_status & next_mask & gate);
        next_chan_fault  = sc_rep | wb_rep;
        next_group_fault = |(sc_rep | wb_rep);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dly_sel               <= DLY_RESET;
            diag_ie               <= 1'b0;
            hw_ie                 <= 1'b0;
            sc_en                 <= '0;
            wb_en                 <= '0;
            rise_en               <= '0;
            fall_en               <= '0;
            status                <= '0;
            mask                  <= '0;
            irq                   <= 1'b0;
            group_fault_indicator <= 1'b0;
            chan_fault            <= '0;
        end
        else
        begin
            dly_sel               <= next_dly_sel;
            diag_ie               <= next_diag_ie;
            hw_ie                 <= next_hw_ie;
            sc_en                 <= next_sc_en;
            wb_en                 <= next_wb_en;
            rise_en               <= next_rise_en;
            fall_en               <= next_fall_en;
            status                <= next_status;
            mask                  <= next_mask;
            irq                   <= next_irq;
            group_fault_indicator <= next_group_fault;
            chan_fault            <= next_chan_fault;
        end
    end
endmodule

// >>> dif_pkg.sv
// Constants shared by the eight-channel filtered input block.
// Assumes a single 50 MHz clock; all timing counts derive from it.
package dif_pkg;

    localparam int NCH        = 8;
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 32;

    // Time base: the debounce counters advance on a 100 us tick
    localparam int CLK_HZ     = 50_000_000;
    localparam int TICK_US    = 100;
    localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
    localparam int CNT_W      = 8;

    // Selectable debounce delays, in microseconds
    localparam int DLY0_US    = 500;
    localparam int DLY1_US    = 3000;
    localparam int DLY2_US    = 15000;
    localparam int DLY3_US    = 20000;
    localparam logic [CNT_W-1:0] DLY0_TICKS = CNT_W'(DLY0_US / TICK_US);
    localparam logic [CNT_W-1:0] DLY1_TICKS = CNT_W'(DLY1_US / TICK_US);
    localparam logic [CNT_W-1:0] DLY2_TICKS = CNT_W'(DLY2_US / TICK_US);
    localparam logic [CNT_W-1:0] DLY3_TICKS = CNT_W'(DLY3_US / TICK_US);

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_SC_EN   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_WB_EN   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_RISE_EN = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_FALL_EN = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_LEVEL   = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_MASK    = 8'h1c;

    // Control register fields
    localparam int CTRL_DLY_LSB = 0;
    localparam int CTRL_DIAG_IE = 2;
    localparam int CTRL_HW_IE   = 3;
    localparam logic [1:0] DLY_RESET = 2'h1;

    // Status and mask layout: four groups of NCH bits
    localparam int ST_RISE = 0;
    localparam int ST_FALL = 8;
    localparam int ST_SC   = 16;
    localparam int ST_WB   = 24;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> dif_filt_if.sv
// Signals between the top, the tick divider and the debounce filters.
// Assumes one clock domain shared by all three parties.
`timescale 1ns/1ns
interface dif_filt_if
    import dif_pkg::*;
();
    logic                   tick;
    logic [CNT_W-1:0]       limit;
    logic [NCH-1:0]         raw;
    logic [NCH-1:0]         level;
    logic [NCH-1:0]         rise;
    logic [NCH-1:0]         fall;

    modport src  (output tick);
    modport filt (input tick, input limit, input raw, output level, output rise, output fall);
    modport ctrl (input tick, output limit, output raw, input level, input rise, input fall);
endinterface

// >>> dif_tick_div.sv
// Divider giving a one-cycle tick every DIV cycles.
// Assumes aclk and a synchronous active-low reset.
`timescale 1ns/1ns
module dif_tick_div
    import dif_pkg::*;
#(
    parameter int DIV = TICK_CYCLES
)(
    input  wire logic   aclk,
    input  wire logic   aresetn,
    dif_filt_if.src     fi
);
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic        tick;
    logic        next_tick;

    always_comb
    begin
        next_tick = 1'b0;
        next_cnt  = cnt + 32'h1;
        if (cnt >= 32'(DIV - 1))
        begin
            next_cnt  = 32'h0;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt  <= 32'h0;
            tick <= 1'b0;
        end
        else
        begin
            cnt  <= next_cnt;
            tick <= next_tick;
        end
    end

    assign fi.tick = tick;
endmodule

// >>> dif_debounce.sv
// Per-channel debounce filters with edge pulses on the filtered level.
// Assumes raw inputs synchronous to aclk and a common tick and limit.
`timescale 1ns/1ns
module dif_debounce
    import dif_pkg::*;
(
    input  wire logic   aclk,
    input  wire logic   aresetn,
    dif_filt_if.filt    fi
);
    for (genvar i = 0; i < NCH; i++)
    begin : g_ch
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] next_cnt;
        logic             lvl_q;
        logic             rise_q;
        logic             fall_q;
        logic             next_level;
        logic             next_rise;
        logic             next_fall;

        // A level must stay different for the full limit in either direction
        always_comb
        begin
            next_cnt   = '0;
            next_level = lvl_q;
            next_rise  = 1'b0;
            next_fall  = 1'b0;
            if (fi.raw[i] != lvl_q)
            begin
                next_cnt = cnt;
                if (fi.tick)
                begin
                    next_cnt = cnt + CNT_W'(1);
                end
                if (next_cnt >= fi.limit)
                begin
                    next_cnt   = '0;
                    next_level = fi.raw[i];
                    next_rise  = fi.raw[i];
                    next_fall  = !fi.raw[i];
                end
            end
        end

        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                cnt    <= '0;
                lvl_q  <= 1'b0;
                rise_q <= 1'b0;
                fall_q <= 1'b0;
            end
            else
            begin
                cnt    <= next_cnt;
                lvl_q  <= next_level;
                rise_q <= next_rise;
                fall_q <= next_fall;
            end
        end

        // Each channel owns its flops, so every output bit has a single driver
        assign fi.level[i] = lvl_q;
        assign fi.rise[i]  = rise_q;
        assign fi.fall[i]  = fall_q;
    end
endmodule

// >>> dif_axi_host.sv
// Register-bus host standing in for the backplane controller.
// Assumes the slave answers in its own time; only the bench watchdog ends a wait.
`timescale 1ns/1ns
module dif_axi_host
    import dif_pkg::*;
(
    input  wire logic                aclk,
    output logic [ADDR_W-1:0]        s_axi_awaddr,
    output logic                     s_axi_awvalid,
    output logic [DATA_W-1:0]        s_axi_wdata,
    output logic [DATA_W/8-1:0]      s_axi_wstrb,
    output logic                     s_axi_wvalid,
    output logic                     s_axi_bready,
    output logic [ADDR_W-1:0]        s_axi_araddr,
    output logic                     s_axi_arvalid,
    output logic                     s_axi_rready,
    input  wire logic                s_axi_awready,
    input  wire logic                s_axi_wready,
    input  wire logic [1:0]          s_axi_bresp,
    input  wire logic                s_axi_bvalid,
    input  wire logic                s_axi_arready,
    input  wire logic [DATA_W-1:0]   s_axi_rdata,
    input  wire logic [1:0]          s_axi_rresp,
    input  wire logic                s_axi_rvalid
);
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    end

    // Address and data offered together; each dropped only at its own handshake
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      output logic [1:0] resp);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
                break;
        end
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                      output logic [1:0] resp);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
                break;
        end
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule

// >>> dif_top_monitor.sv
// Port-level assertions for the filtered input block.
// Assumes one clock domain; bound into every dif_top instance.
`timescale 1ns/1ns
module dif_top_monitor
    import dif_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
)(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    input  wire logic                s_axi_awready,
    input  wire logic [DATA_W-1:0]   s_axi_wdata,
    input  wire logic [DATA_W/8-1:0] s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    input  wire logic                s_axi_wready,
    input  wire logic [1:0]          s_axi_bresp,
    input  wire logic                s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    input  wire logic                s_axi_arready,
    input  wire logic [DATA_W-1:0]   s_axi_rdata,
    input  wire logic [1:0]          s_axi_rresp,
    input  wire logic                s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic [NCH-1:0]      in_raw,
    input  wire logic [NCH-1:0]      short_det,
    input  wire logic [NCH-1:0]      open_det,
    input  wire logic                irq,
    input  wire logic                group_fault_indicator,
    input  wire logic [NCH-1:0]      chan_fault
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence

    a_reset_quiet:
        assert property ($rose(aresetn) |-> !irq && !s_axi_bvalid && !s_axi_rvalid
            && chan_fault == '0 && !group_fault_indicator)
        else $error("outputs not idle after reset");
    a_write_answer:
        assert property (wr_both |=> !s_axi_awready ##1 s_axi_bvalid && s_axi_bresp ==
            ($past(s_axi_awaddr, 2) > OFS_MASK ? RESP_SLVERR : RESP_OKAY))
        else $error("write answer late or wrong");
    a_read_answer:
        assert property (ar_take |=> s_axi_rvalid && !s_axi_arready && s_axi_rresp ==
            ($past(s_axi_araddr) > OFS_MASK ? RESP_SLVERR : RESP_OKAY))
        else $error("read answer late or wrong");
    a_unmapped_zero:
        assert property (ar_take ##0 s_axi_araddr > OFS_MASK |=> s_axi_rdata == '0)
        else $error("unmapped read data not zero");
    a_b_release:
        assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
            ##1 (s_axi_awready && s_axi_wready))
        else $error("write channel not released");
    a_r_release:
        assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready)
        else $error("read channel not released");
    a_group_or:
        assert property (group_fault_indicator == (|chan_fault))
        else $error("group fault differs from channel faults");
    a_fault_cause:
        assert property ((chan_fault & ~($past(short_det) | $past(open_det))) == '0)
        else $error("channel fault without detector flag");
endmodule

bind dif_top dif_top_monitor #(.TICK_DIV(TICK_DIV)) dif_top_monitor_inst (.*);

// >>> testbench.sv
// Self-checking bench for the filtered input block, registers over AXI4-Lite.
// Assumes the bus host model and the bound port monitor compile alongside.
`timescale 1ns/1ns
module testbench
    import dif_pkg::*;
;
    // Short tick keeps the 20 ms delay to 800 cycles
    localparam int TD = 4;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} dif_row_s;
    logic                aclk = 1'b0;
    logic                aresetn = 1'b0;
    logic [NCH-1:0]      in_raw = '0;
    logic [NCH-1:0]      short_det = '0;
    logic [NCH-1:0]      open_det = '0;
    logic [ADDR_W-1:0]   s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0]   s_axi_wdata, s_axi_rdata;
    logic [DATA_W/8-1:0] s_axi_wstrb;
    logic [1:0]          s_axi_bresp, s_axi_rresp, rsp;
    logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic                s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic                s_axi_rvalid, s_axi_rready, irq, group_fault_indicator, lvl;
    logic [NCH-1:0]      chan_fault;
    logic [31:0]         rdv;
    int                  err_total = 0;
    int                  checks_done = 0;
    int                  lims [4] = '{DLY0_TICKS, DLY1_TICKS, DLY2_TICKS, DLY3_TICKS};
    dif_row_s            rows [9] = '{
        '{OFS_RISE_EN, 32'hff, 32'h0},
        '{OFS_CTRL, 32'h8, 32'h8},
        '{OFS_RISE_EN, 32'hff, 32'hff},
        '{OFS_FALL_EN, 32'h0f, 32'h0f},
        '{OFS_SC_EN, 32'ha5, 32'ha5},
        '{OFS_WB_EN, 32'h5a, 32'h5a},
        '{OFS_MASK, 32'hffff_ffff, 32'hffff_ffff},
        '{OFS_LEVEL, 32'hff, 32'h0},
        '{8'h20, 32'h1, 32'h0}};

    dif_top #(.TICK_DIV(TD)) dif_top_inst (.*);
    dif_axi_host dif_axi_host_inst (.*);

    always #10 aclk = ~aclk;

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Every access also checks the response code that its address calls for
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        dif_axi_host_inst.wr(a, d, rsp);
        chk(32'(rsp), 32'(a > OFS_MASK ? RESP_SLVERR : RESP_OKAY));
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        dif_axi_host_inst.rd(a, rdv, rsp);
        chk(rdv, e);
        chk(32'(rsp), 32'(a > OFS_MASK ? RESP_SLVERR : RESP_OKAY));
    endtask

    task automatic reset_regs();
        for (int i = 0; i < 8; i++)
            rd(8'(4 * i), (i == 0) ? 32'(DLY_RESET) : 32'h0);
        chk(32'(irq), 32'h0);
    endtask

    initial
    begin
        cyc(4);
        aresetn <= 1'b1;
        reset_regs();
        $display("test reset_values done");
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        $display("test register_rows done");
        lvl = 1'b0;
        for (int s = 0; s < 4; s++)
        begin
            wr(OFS_CTRL, 32'(s) | 32'h8);
            repeat (2)
            begin
                @(posedge aclk);
                in_raw[0] <= ~lvl;
                cyc((lims[s] - 2) * TD);
                rd(OFS_LEVEL, 32'(lvl));
                cyc(4 * TD);
                lvl = ~lvl;
                rd(OFS_LEVEL, 32'(lvl));
            end
        end
        $display("test debounce done");
        chk(32'(irq), 32'h1);
        rd(OFS_STATUS, 32'h0000_0101);
        wr(OFS_STATUS, 32'h0000_0101);
        rd(OFS_STATUS, 32'h0);
        cyc(2);
        chk(32'(irq), 32'h0);
        wr(OFS_CTRL, 32'h0);
        wr(OFS_RISE_EN, 32'h0);
        rd(OFS_RISE_EN, 32'hff);
        in_raw[1] <= 1'b1;
        cyc((lims[0] + 3) * TD);
        rd(OFS_LEVEL, 32'h2);
        rd(OFS_STATUS, 32'h0);
        chk(32'(irq), 32'h0);
        $display("test edge_irq done");
        short_det <= 8'hff;
        cyc(3);
        chk(32'(chan_fault), 32'ha5);
        chk(32'(group_fault_indicator), 32'h1);
        rd(OFS_STATUS, 32'h00a5_0000);
        chk(32'(irq), 32'h0);
        wr(OFS_CTRL, 32'h4);
        cyc(2);
        chk(32'(irq), 32'h1);
        short_det <= 8'h0;
        open_det <= 8'hff;
        cyc(3);
        wr(OFS_STATUS, 32'hffff_ffff);
        rd(OFS_STATUS, 32'h5a00_0000);
        chk(32'(chan_fault), 32'h5a);
        open_det <= 8'h0;
        cyc(3);
        wr(OFS_STATUS, 32'hffff_ffff);
        rd(OFS_STATUS, 32'h0);
        cyc(2);
        chk(32'(irq), 32'h0);
        chk(32'(chan_fault), 32'h0);
        $display("test diag_irq done");
        in_raw <= '0;
        aresetn <= 1'b0;
        cyc(4);
        aresetn <= 1'b1;
        reset_regs();
        $display("test mid_reset done");
        end_of_test();
    end

    initial
    begin
        cyc(20000);
        err_total++;
        end_of_test();
    end
endmodule
